// *** cesp_pkg.sv ***
package cesp_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFF_EVT_SEL = 8'h00;
   localparam logic [7:0] OFF_EVT_NOTIFY = 8'h04;
   localparam logic [7:0] OFF_EVT_PEND = 8'h08;
   localparam logic [7:0] OFF_STAT_SEL = 8'h0C;
   localparam logic [7:0] OFF_STAT_VAL = 8'h10;
   localparam logic [7:0] OFF_STAT_CLR = 8'h14;
   localparam logic [7:0] OFF_SYNC_MODE = 8'h18;
   localparam logic [7:0] OFF_SYNC_STATE = 8'h1C;
   localparam logic [7:0] OFF_CNT1_TARGET = 8'h20;
   localparam logic [7:0] OFF_EVT_POP = 8'h24;
   localparam logic [7:0] OFF_MSG_OUT = 8'h28;

   // event type codes
   localparam logic [1:0] EVT_REJ_TRIG = 2'h0;
   localparam logic [1:0] EVT_DROP_IMG = 2'h1;
   localparam logic [1:0] EVT_CNT1_DONE = 2'h2;
   localparam logic [1:0] EVT_OVERFLOW = 2'h3;
   localparam int NUM_EVT = 4;

   // notification values
   localparam logic [1:0] NOTIFY_OFF = 2'h0;
   localparam logic [1:0] NOTIFY_ON = 2'h1;
   localparam logic [1:0] NOTIFY_LEGACY = 2'h2;

   // statistic selector codes
   localparam logic [2:0] STAT_REJ_TRIG = 3'h0;
   localparam logic [2:0] STAT_DROP_IMG = 3'h1;
   localparam logic [2:0] STAT_RETX = 3'h2;
   localparam logic [2:0] STAT_RETX_DROP = 3'h3;
   localparam logic [2:0] STAT_PAUSE = 3'h4;
   localparam int NUM_STAT = 5;
   localparam int STAT_W = 32;
   localparam logic [STAT_W-1:0] PAUSE_MAX = 32'h0001_0000;
   localparam logic [STAT_W-1:0] STAT_MAX = 32'hFFFF_FFFF;
   localparam logic [STAT_W-1:0] STAT_RESET = 32'h0000_0000;

   // message store and init state length
   localparam int MSG_DEPTH = 4;
   localparam int MSG_PW = 2;
   localparam int INIT_CYCLES = 8;

   typedef enum logic [1:0] {
      CESP_MODE_OFF = 2'b00,
      CESP_MODE_AUTO = 2'b01,
      CESP_MODE_SLAVE = 2'b10
   } cesp_mode_t;

   typedef enum logic [3:0] {
      CESP_ST_INIT = 4'b0000,
      CESP_ST_FAULTY = 4'b0001,
      CESP_ST_DISABLED = 4'b0010,
      CESP_ST_LISTENING = 4'b0011,
      CESP_ST_PREMASTER = 4'b0100,
      CESP_ST_MASTER = 4'b0101,
      CESP_ST_PASSIVE = 4'b0110,
      CESP_ST_UNCAL = 4'b0111,
      CESP_ST_SLAVE = 4'b1000
   } cesp_state_t;

   // acquisition/link strobes into the block
   typedef struct packed {
      logic frame_trigger;
      logic trigger_allowed;
      logic image_dropped;
      logic counter_one_tick;
      logic retransmit;
      logic retransmit_req;
      logic retransmit_q_full;
      logic pause_rx;
   } cesp_evin_t;

   // time-sync engine observations
   typedef struct packed {
      logic announce_seen;
      logic master_better;
      logic servo_locked;
      logic fault;
      logic msg_rx;
      logic msg_is_mgmt;
   } cesp_sync_in_t;
endpackage : cesp_pkg

// *** cesp_stat_counter.sv ***
`timescale 1ns/1ps
module cesp_stat_counter (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic inc, // count one event
   input wire logic clr, // clear to zero
   input wire logic [cesp_pkg::STAT_W-1:0] max_val, // saturation ceiling
   output logic [cesp_pkg::STAT_W-1:0] count // current count
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= cesp_pkg::STAT_RESET;
      end else if (clr) begin
         count <= cesp_pkg::STAT_RESET;
      end else if (inc && count != max_val) begin
         count <= count + 32'h0000_0001;
      end
   end
endmodule : cesp_stat_counter

// *** cesp_ctrl.sv ***
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - trigger in refused region raises rejected event
// - image dropped for memory raises event
// - counter one reaching target raises event
// - notify enable off suppresses, on emits
// - legacy notify value acts like on
// - selected statistic counter is reported
// - clear command clears selected counter only
// - rejected triggers counted
// - discarded images counted
// - each retransmitted packet counted
// - dropped resend requests still counted
// - pause frame count limited to 65536
// - mode off: no time-sync activity
// - automatic mode may become master
// - slave mode never becomes master
// - port state readable, updated live
// - initializing sends no messages
// - event selector picks notify entry
// - disabled drops all but management messages
// - slave state while synchronizing to master
module cesp_ctrl (
   input wire logic pclk, // clock 50 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire cesp_pkg::cesp_evin_t evin, // acquisition and link strobes
   input wire cesp_pkg::cesp_sync_in_t sync_in, // time-sync observations
   output logic trigger_accept, // trigger starts acquisition
   output logic msg_valid, // event message pending for host
   output logic [1:0] msg_type, // type of head message
   output logic sync_tx_enable, // time-sync messages may be sent
   output logic sync_rx_accept, // received time-sync message kept
   output logic sync_is_master // acting as master
);
   logic [1:0] evt_sel_r;
   logic [1:0] notify_r [cesp_pkg::NUM_EVT];
   logic [2:0] stat_sel_r;
   cesp_pkg::cesp_mode_t mode_r;
   cesp_pkg::cesp_state_t state_r;
   cesp_pkg::cesp_state_t state_nxt;
   logic [31:0] cnt1_target_r;
   logic [31:0] cnt1_r;
   logic [1:0] msg_q [cesp_pkg::MSG_DEPTH];
   logic [cesp_pkg::MSG_PW-1:0] wr_ptr_r;
   logic [cesp_pkg::MSG_PW-1:0] rd_ptr_r;
   logic [cesp_pkg::MSG_PW:0] q_cnt_r;
   logic [3:0] init_cnt_r;
   logic [cesp_pkg::STAT_W-1:0] stat_cnt [cesp_pkg::NUM_STAT];
   logic [cesp_pkg::NUM_STAT-1:0] stat_inc;
   logic [cesp_pkg::NUM_STAT-1:0] stat_clr;
   logic wr_en;
   logic rd_en;
   logic rej_trig;
   logic cnt1_done;
   logic [cesp_pkg::NUM_EVT-1:0] evt_raw;
   logic [cesp_pkg::NUM_EVT-1:0] evt_gated;
   logic push;
   logic pop;
   logic [1:0] push_type;
   logic overflow;
   logic addr_ok;

   function automatic logic notify_active(input logic [1:0] v);
      notify_active = (v == cesp_pkg::NOTIFY_ON) || (v == cesp_pkg::NOTIFY_LEGACY);
   endfunction : notify_active

   function automatic cesp_pkg::cesp_mode_t cesp_cast_mode(input logic [1:0] v);
      cesp_cast_mode = cesp_pkg::cesp_mode_t'(v);
   endfunction : cesp_cast_mode

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign addr_ok = (paddr <= cesp_pkg::OFF_MSG_OUT) && (paddr[1:0] == 2'h0);

   // event sources
   assign rej_trig = evin.frame_trigger && !evin.trigger_allowed;
   assign cnt1_done = evin.counter_one_tick && (cnt1_r + 32'h0000_0001 == cnt1_target_r);
   always_comb begin
      evt_raw = '0;
      evt_raw[cesp_pkg::EVT_REJ_TRIG] = rej_trig;
      evt_raw[cesp_pkg::EVT_DROP_IMG] = evin.image_dropped;
      evt_raw[cesp_pkg::EVT_CNT1_DONE] = cnt1_done;
      for (int i = 0; i < cesp_pkg::NUM_EVT; i++) begin
         evt_gated[i] = evt_raw[i] && notify_active(notify_r[i]);
      end
   end

   // one message per cycle; lowest type code wins when several coincide
   always_comb begin
      push_type = 2'h0;
      push = 1'b0;
      for (int i = cesp_pkg::NUM_EVT - 1; i >= 0; i--) begin
         if (evt_gated[i]) begin
            push = 1'b1;
            push_type = 2'(i);
         end
      end
   end
   assign pop = wr_en && paddr == cesp_pkg::OFF_EVT_POP && q_cnt_r != 3'h0;
   assign overflow = push && !pop && q_cnt_r == 3'(cesp_pkg::MSG_DEPTH);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt1_r <= 32'h0000_0000;
      end else if (evin.counter_one_tick) begin
         cnt1_r <= cnt1_done ? 32'h0000_0000 : cnt1_r + 32'h0000_0001;
      end
   end

   // message store; overflow replaces the newest slot by the overflow message
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         q_cnt_r <= '0;
      end else begin
         if (overflow) begin
            msg_q[wr_ptr_r - 2'h1] <= cesp_pkg::EVT_OVERFLOW;
         end else if (push) begin
            msg_q[wr_ptr_r] <= push_type;
            wr_ptr_r <= wr_ptr_r + 2'h1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
         end
         if (push && !overflow && !pop) begin
            q_cnt_r <= q_cnt_r + 3'h1;
         end else if (pop && !push) begin
            q_cnt_r <= q_cnt_r - 3'h1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_sel_r <= cesp_pkg::EVT_REJ_TRIG;
         stat_sel_r <= cesp_pkg::STAT_REJ_TRIG;
         mode_r <= cesp_pkg::CESP_MODE_OFF;
         cnt1_target_r <= 32'h0000_0001;
         for (int i = 0; i < cesp_pkg::NUM_EVT; i++) begin
            notify_r[i] <= cesp_pkg::NOTIFY_OFF;
         end
      end else begin
         if (overflow) begin
            for (int i = 0; i < cesp_pkg::NUM_EVT; i++) begin
               // overflow entry keeps its setting; the overflow message is stored whatever that setting is
               if (i != cesp_pkg::EVT_OVERFLOW) notify_r[i] <= cesp_pkg::NOTIFY_OFF;
            end
         end
         if (wr_en) begin
            case (paddr)
               cesp_pkg::OFF_EVT_SEL: evt_sel_r <= pwdata[1:0];
               cesp_pkg::OFF_EVT_NOTIFY: begin
                  if (pwdata[1:0] != 2'h3) notify_r[evt_sel_r] <= pwdata[1:0];
               end
               cesp_pkg::OFF_STAT_SEL: begin
                  if (pwdata[2:0] < 3'(cesp_pkg::NUM_STAT)) stat_sel_r <= pwdata[2:0];
               end
               cesp_pkg::OFF_SYNC_MODE: begin
                  if (pwdata[1:0] != 2'h3) mode_r <= cesp_cast_mode(pwdata[1:0]);
               end
               cesp_pkg::OFF_CNT1_TARGET: cnt1_target_r <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // statistics
   always_comb begin
      stat_inc = '0;
      stat_clr = '0;
      stat_inc[cesp_pkg::STAT_REJ_TRIG] = rej_trig;
      stat_inc[cesp_pkg::STAT_DROP_IMG] = evin.image_dropped;
      stat_inc[cesp_pkg::STAT_RETX] = evin.retransmit;
      stat_inc[cesp_pkg::STAT_RETX_DROP] = evin.retransmit_req && evin.retransmit_q_full;
      stat_inc[cesp_pkg::STAT_PAUSE] = evin.pause_rx;
      if (wr_en && paddr == cesp_pkg::OFF_STAT_CLR && pwdata[0]) begin
         stat_clr[stat_sel_r] = 1'b1;
      end
   end

   for (genvar g = 0; g < cesp_pkg::NUM_STAT; g++) begin : g_stat
      cesp_stat_counter u_cnt (
         .pclk(pclk),
         .presetn(presetn),
         .inc(stat_inc[g]),
         .clr(stat_clr[g]),
         .max_val(g == cesp_pkg::STAT_PAUSE ? cesp_pkg::PAUSE_MAX : cesp_pkg::STAT_MAX),
         .count(stat_cnt[g])
      );
   end

   // port state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cesp_pkg::CESP_ST_DISABLED: begin
            if (mode_r != cesp_pkg::CESP_MODE_OFF) state_nxt = cesp_pkg::CESP_ST_INIT;
         end
         cesp_pkg::CESP_ST_INIT: begin
            if (init_cnt_r == 4'(cesp_pkg::INIT_CYCLES)) state_nxt = cesp_pkg::CESP_ST_LISTENING;
         end
         cesp_pkg::CESP_ST_LISTENING: begin
            if (sync_in.announce_seen && !sync_in.master_better) begin
               state_nxt = cesp_pkg::CESP_ST_UNCAL;
            end else if (!sync_in.announce_seen && mode_r == cesp_pkg::CESP_MODE_AUTO) begin
               state_nxt = cesp_pkg::CESP_ST_PREMASTER;
            end
         end
         cesp_pkg::CESP_ST_PREMASTER: state_nxt = cesp_pkg::CESP_ST_MASTER;
         cesp_pkg::CESP_ST_MASTER: begin
            if (!sync_in.master_better) state_nxt = cesp_pkg::CESP_ST_UNCAL;
         end
         cesp_pkg::CESP_ST_UNCAL: begin
            if (sync_in.servo_locked) state_nxt = cesp_pkg::CESP_ST_SLAVE;
         end
         cesp_pkg::CESP_ST_SLAVE: begin
            if (!sync_in.servo_locked) state_nxt = cesp_pkg::CESP_ST_UNCAL;
            else if (sync_in.master_better && mode_r == cesp_pkg::CESP_MODE_AUTO) begin
               state_nxt = cesp_pkg::CESP_ST_PREMASTER;
            end
         end
         cesp_pkg::CESP_ST_FAULTY: state_nxt = cesp_pkg::CESP_ST_INIT;
         default: state_nxt = cesp_pkg::CESP_ST_INIT;
      endcase
      if (state_r != cesp_pkg::CESP_ST_DISABLED && sync_in.fault) state_nxt = cesp_pkg::CESP_ST_FAULTY;
      if (mode_r == cesp_pkg::CESP_MODE_SLAVE && (state_nxt == cesp_pkg::CESP_ST_PREMASTER
          || state_nxt == cesp_pkg::CESP_ST_MASTER)) state_nxt = cesp_pkg::CESP_ST_LISTENING;
      if (mode_r == cesp_pkg::CESP_MODE_OFF) state_nxt = cesp_pkg::CESP_ST_DISABLED;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= cesp_pkg::CESP_ST_DISABLED;
         init_cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         init_cnt_r <= (state_r == cesp_pkg::CESP_ST_INIT) ? init_cnt_r + 4'h1 : 4'h0;
      end
   end

   // port-facing outputs, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_tx_enable <= 1'b0;
         sync_rx_accept <= 1'b0;
         sync_is_master <= 1'b0;
         trigger_accept <= 1'b0;
         msg_valid <= 1'b0;
         msg_type <= 2'h0;
      end else begin
         sync_tx_enable <= state_nxt != cesp_pkg::CESP_ST_DISABLED
                           && state_nxt != cesp_pkg::CESP_ST_INIT
                           && state_nxt != cesp_pkg::CESP_ST_FAULTY;
         sync_rx_accept <= sync_in.msg_rx && (state_nxt != cesp_pkg::CESP_ST_DISABLED
                           || sync_in.msg_is_mgmt);
         sync_is_master <= state_nxt == cesp_pkg::CESP_ST_MASTER;
         trigger_accept <= evin.frame_trigger && evin.trigger_allowed;
         msg_valid <= q_cnt_r != 3'h0;
         // store slots are never reset, so an empty store shows type 0
         msg_type <= (q_cnt_r != 3'h0) ? msg_q[rd_ptr_r] : 2'h0;
      end
   end

   // apb slave: zero wait states, read data captured in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_en) begin
            case (paddr)
               cesp_pkg::OFF_EVT_SEL: prdata <= {30'h0, evt_sel_r};
               cesp_pkg::OFF_EVT_NOTIFY: prdata <= {30'h0, notify_r[evt_sel_r]};
               cesp_pkg::OFF_EVT_PEND: prdata <= {29'h0, q_cnt_r};
               cesp_pkg::OFF_STAT_SEL: prdata <= {29'h0, stat_sel_r};
               cesp_pkg::OFF_STAT_VAL: prdata <= stat_cnt[stat_sel_r];
               cesp_pkg::OFF_SYNC_MODE: prdata <= {30'h0, mode_r};
               cesp_pkg::OFF_SYNC_STATE: prdata <= {28'h0, state_r};
               cesp_pkg::OFF_CNT1_TARGET: prdata <= cnt1_target_r;
               cesp_pkg::OFF_MSG_OUT: prdata <= {29'h0, q_cnt_r != 3'h0, msg_q[rd_ptr_r]};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : cesp_ctrl

// *** cesp_ctrl_properties.sv ***
`timescale 1ns/1ps
module cesp_ctrl_properties (
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // write
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // wdata
   input wire logic [31:0] prdata, // rdata
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire cesp_pkg::cesp_evin_t evin, // strobes
   input wire cesp_pkg::cesp_sync_in_t sync_in, // sync inputs
   input wire logic trigger_accept, // accept
   input wire logic msg_valid, // pending
   input wire logic [1:0] msg_type, // head type
   input wire logic sync_tx_enable, // tx gate
   input wire logic sync_rx_accept, // rx keep
   input wire logic sync_is_master // master
);
   logic [1:0] mode_r;
   // shadow of the mode register, value 3 is refused by the design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 2'h0;
      end else if (psel && penable && pready && pwrite && paddr == cesp_pkg::OFF_SYNC_MODE
            && pwdata[1:0] != 2'h3) begin
         mode_r <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   // margin of a few cycles: state and outputs lag the mode write
   sequence off_s;
      (mode_r == 2'h0)[*3];
   endsequence
   sequence slave_s;
      (mode_r == 2'h2)[*4];
   endsequence
   trig_accept_a: assert property (evin.frame_trigger && evin.trigger_allowed |=> trigger_accept)
      else $error("allowed trigger not accepted");
   trig_refuse_a: assert property (evin.frame_trigger && !evin.trigger_allowed |=> !trigger_accept)
      else $error("refused trigger was accepted");
   apb_answer_a: assert property (setup_s |=> pready && penable)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   sync_off_a: assert property (off_s |-> !sync_tx_enable && !sync_is_master)
      else $error("time sync active in mode off");
   slave_only_a: assert property (slave_s |-> !sync_is_master)
      else $error("master in slave mode");
   rx_accept_a: assert property (sync_rx_accept |-> $past(sync_in.msg_rx))
      else $error("accept without received message");
   rx_mgmt_a: assert property (off_s |-> !sync_rx_accept || $past(sync_in.msg_is_mgmt))
      else $error("non-management message kept while disabled");
endmodule : cesp_ctrl_properties

bind cesp_ctrl cesp_ctrl_properties cesp_ctrl_properties_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .evin(evin), .sync_in(sync_in),
   .trigger_accept(trigger_accept), .msg_valid(msg_valid), .msg_type(msg_type),
   .sync_tx_enable(sync_tx_enable), .sync_rx_accept(sync_rx_accept),
   .sync_is_master(sync_is_master));

// *** cesp_host_model.sv ***
`timescale 1ns/1ps
module cesp_host_model (
   input wire logic pclk, // clock
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   output logic psel, // select
   output logic penable, // enable
   output logic pwrite, // direction
   output logic [7:0] paddr, // address
   output logic [31:0] pwdata // write data
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines do not keep the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : cesp_host_model

// *** cesp_ctrl_bench.sv ***
`timescale 1ns/1ps
module cesp_ctrl_bench;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] v;
      logic err;
   } cesp_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trigger_accept, msg_valid;
   logic sync_tx_enable, sync_rx_accept, sync_is_master, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0] msg_type;
   cesp_pkg::cesp_evin_t evin;
   cesp_pkg::cesp_sync_in_t sync_in;
   int num_errors, compares, cycles;
   cesp_row_t rows [16];
   cesp_ctrl cesp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evin(evin), .sync_in(sync_in), .trigger_accept(trigger_accept),
      .msg_valid(msg_valid), .msg_type(msg_type), .sync_tx_enable(sync_tx_enable),
      .sync_rx_accept(sync_rx_accept), .sync_is_master(sync_is_master));
   cesp_host_model cesp_host_model_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cesp_host_model_inst.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      cesp_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
      chk($sformatf("register %h", a), x, q);
   endtask : rc
   task automatic pulse(input logic [7:0] v, input int n);
      repeat (n) begin
         @(posedge pclk);
         evin <= cesp_pkg::cesp_evin_t'(v);
         @(posedge pclk);
         evin <= 8'h00;
      end
   endtask : pulse
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         $display("timeout");
         summarize();
      end
   end
   initial begin
      presetn = 1'b0;
      evin = 8'h00;
      sync_in = 6'h00;
      rows = '{'{1'b0, 8'h1C, 32'h2, 1'b0}, '{1'b0, 8'h18, 32'h0, 1'b0},
         '{1'b0, 8'h04, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 1'b0},
         '{1'b0, 8'h20, 32'h1, 1'b0}, '{1'b0, 8'h08, 32'h0, 1'b0},
         '{1'b1, 8'h04, 32'h2, 1'b0}, '{1'b0, 8'h04, 32'h2, 1'b0},
         '{1'b1, 8'h00, 32'h1, 1'b0}, '{1'b0, 8'h04, 32'h0, 1'b0},
         '{1'b1, 8'h04, 32'h3, 1'b0}, '{1'b0, 8'h04, 32'h0, 1'b0},
         '{1'b1, 8'h0C, 32'h5, 1'b0}, '{1'b0, 8'h0C, 32'h0, 1'b0},
         '{1'b0, 8'h30, 32'h0, 1'b1}, '{1'b0, 8'h02, 32'h0, 1'b1}};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         cesp_host_model_inst.xfer(rows[i].w, rows[i].a, rows[i].w ? rows[i].v : 32'h0, q, e);
         if (!rows[i].w) chk($sformatf("row %0d data", i), rows[i].v, q);
         chk($sformatf("row %0d error", i), {31'h0, rows[i].err}, {31'h0, e});
      end
      $display("register table done");
      pulse(8'h80, 2);
      pulse(8'hC0, 1);
      rc(8'h10, 32'h2);
      rc(8'h08, 32'h2);
      rc(8'h28, 32'h4);
      @(negedge pclk);
      chk("msg_valid", 32'h1, {31'h0, msg_valid});
      chk("msg_type", 32'h0, {30'h0, msg_type});
      wr(8'h24, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h04, 32'h1);
      pulse(8'h20, 1);
      rc(8'h28, 32'h5);
      wr(8'h24, 32'h0);
      wr(8'h0C, 32'h1);
      rc(8'h10, 32'h1);
      wr(8'h20, 32'h2);
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h1);
      pulse(8'h10, 1);
      rc(8'h08, 32'h0);
      pulse(8'h10, 1);
      rc(8'h28, 32'h6);
      @(negedge pclk);
      chk("msg_type", 32'h2, {30'h0, msg_type});
      wr(8'h24, 32'h0);
      $display("event tests done");
      pulse(8'h08, 3);
      pulse(8'h06, 1);
      wr(8'h0C, 32'h2);
      rc(8'h10, 32'h3);
      wr(8'h14, 32'h1);
      rc(8'h10, 32'h0);
      wr(8'h0C, 32'h3);
      rc(8'h10, 32'h1);
      $display("statistic tests done");
      wr(8'h00, 32'h0);
      pulse(8'h80, 5);
      rc(8'h08, 32'h4);
      rc(8'h04, 32'h0);
      wr(8'h04, 32'h1);
      repeat (3) wr(8'h24, 32'h0);
      rc(8'h28, 32'h7);
      @(negedge pclk);
      chk("msg_type", 32'h3, {30'h0, msg_type});
      wr(8'h24, 32'h0);
      rc(8'h08, 32'h0);
      @(negedge pclk);
      chk("msg_valid", 32'h0, {31'h0, msg_valid});
      $display("overflow test done");
      @(posedge pclk);
      evin <= 8'h01;
      repeat (65540) @(posedge pclk);
      evin <= 8'h00;
      wr(8'h0C, 32'h4);
      rc(8'h10, 32'h0001_0000);
      wr(8'h0C, 32'h3);
      rc(8'h10, 32'h1);
      $display("pause saturation test done");
      // foreign master announced and better than us, servo locks
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h28);
      wr(8'h18, 32'h2);
      repeat (3) begin
         @(posedge pclk);
         sync_in.msg_rx <= 1'b1;
         @(posedge pclk);
         sync_in.msg_rx <= 1'b0;
      end
      repeat (40) @(posedge pclk);
      rc(8'h1C, 32'h8);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h00);
      wr(8'h18, 32'h1);
      repeat (40) @(posedge pclk);
      wr(8'h18, 32'h0);
      repeat (10) @(posedge pclk);
      rc(8'h1C, 32'h2);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h10);
      wr(8'h18, 32'h1);
      repeat (20) @(posedge pclk);
      rc(8'h1C, 32'h5);
      @(negedge pclk);
      chk("sync_is_master", 32'h1, {31'h0, sync_is_master});
      chk("sync_tx_enable", 32'h1, {31'h0, sync_tx_enable});
      wr(8'h18, 32'h2);
      repeat (5) @(posedge pclk);
      rc(8'h1C, 32'h3);
      @(negedge pclk);
      chk("sync_is_master", 32'h0, {31'h0, sync_is_master});
      wr(8'h18, 32'h0);
      repeat (5) @(posedge pclk);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h02);
      @(posedge pclk);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h00);
      @(negedge pclk);
      chk("sync_rx_accept", 32'h0, {31'h0, sync_rx_accept});
      chk("sync_tx_enable", 32'h0, {31'h0, sync_tx_enable});
      @(posedge pclk);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h03);
      @(posedge pclk);
      sync_in <= cesp_pkg::cesp_sync_in_t'(6'h00);
      @(negedge pclk);
      chk("sync_rx_accept", 32'h1, {31'h0, sync_rx_accept});
      $display("time sync tests done");
      summarize();
   end
endmodule : cesp_ctrl_bench
